// >>> include/ovl_recovery_defines.vh
`ifndef OVL_RECOVERY_DEFINES_VH
`define OVL_RECOVERY_DEFINES_VH

`define SAMPLE_W 5
`define CODE_POS_FS 5'h08
`define CODE_NEG_FS 5'h18
`define WINDOW_LEN 8
`define HIT_LIMIT 4'h5
`define HOLD_CYCLES 8'h10
`define RAMP_CYCLES 8'h30
`define VALID_CYCLES 8'h40
`define ATTEN_W 5
`define ATTEN_BOOST 5'h06
`define ATTEN_MAX 5'h1F

`endif

// >>> verilog/ovl_recovery.v
`timescale 1ns/100ps
`include "ovl_recovery_defines.vh"

// Function
// - Take one 5-bit quantizer sample per clock and check it for full scale.
// - Samples are signed -8..+8; full scale is code +8 or code -8.
// - Overload when more than five of the last eight samples are full scale.
// - On overload zero modulator state and add 6 dB attenuation.
// - Hold modulator reset for 16 clocks, then release it.
// - Return added attenuation to programmed value over the next 48 clocks.
// - New overload during or after recovery restarts the whole sequence.
// - Output marked clean 65 clocks after the last overload detection.
module ovl_recovery (
  // Clock and control
  input wire SYS_CLK,
  input wire SRST,
  input wire CE,
  // Quantizer sample stream
  input wire [`SAMPLE_W-1:0] QSAMPLE,
  input wire QSAMPLE_VALID,
  output reg QSAMPLE_READY,
  // Programmed attenuation in 1 dB steps
  input wire [`ATTEN_W-1:0] ATTEN_PROG,
  // Modulator controls
  output reg MOD_RESET,
  output reg [`ATTEN_W-1:0] ATTEN_OUT,
  output reg OVERLOAD,
  output reg RECOVERING,
  // Sample output stream
  output reg [`SAMPLE_W-1:0] OUT_DATA,
  output reg OUT_VALID,
  output reg OUT_CLEAN,
  input wire OUT_READY
);

  localparam ST_IDLE = 2'h0;
  localparam ST_HOLD = 2'h1;
  localparam ST_RAMP = 2'h2;

  // Sequencer state
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] cnt_q;
  reg [7:0] cnt_d;
  reg [7:0] quiet_q;
  reg [`ATTEN_W-1:0] extra_q;
  reg [`ATTEN_W-1:0] extra_d;
  reg mod_reset_d;
  // Full-scale history, newest sample in bit 0
  reg [`WINDOW_LEN-1:0] hist_q;
  // Two-entry buffer toward the receiver
  reg [`SAMPLE_W-1:0] buf0_q;
  reg [`SAMPLE_W-1:0] buf1_q;
  reg [`SAMPLE_W-1:0] buf0_d;
  reg [`SAMPLE_W-1:0] buf1_d;
  reg [1:0] fill_q;
  reg [1:0] fill_d;
  wire take;
  wire pop;
  wire full_scale;
  wire overload_now;
  wire [3:0] hits;
  wire [3:0] psum [0:`WINDOW_LEN];
  wire [`WINDOW_LEN-1:0] hist_next;
  wire [`ATTEN_W:0] atten_sum;
  genvar g;

  // Only a sample the buffer has room for is taken and judged
  assign take = CE & QSAMPLE_VALID & QSAMPLE_READY;
  assign pop = OUT_VALID & OUT_READY;
  assign full_scale = (QSAMPLE == `CODE_POS_FS) |
                      (QSAMPLE == `CODE_NEG_FS);
  assign hist_next = {hist_q[`WINDOW_LEN-2:0], full_scale};

  // Population count of the window, one adder per position
  assign psum[0] = 4'h0;
  generate
    for (g = 0; g < `WINDOW_LEN; g = g + 1) begin : g_hits
      assign psum[g+1] = psum[g] + {3'h0, hist_next[g]};
    end
  endgenerate
  assign hits = psum[`WINDOW_LEN];
  assign overload_now = take & (hits > `HIT_LIMIT);

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    extra_d = extra_q;
    mod_reset_d = MOD_RESET;
    if (overload_now) begin
      // Restart even mid-sequence; history is wiped with the modulator
      state_d = ST_HOLD;
      cnt_d = 8'h00;
      extra_d = `ATTEN_BOOST;
      mod_reset_d = 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          extra_d = {`ATTEN_W{1'b0}};
          mod_reset_d = 1'b0;
        end
        ST_HOLD: begin
          if (cnt_q == `HOLD_CYCLES - 8'h01) begin
            mod_reset_d = 1'b0;
            state_d = ST_RAMP;
            cnt_d = 8'h00;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        ST_RAMP: begin
          // One dB step every eighth clock spreads 6 dB over 48 clocks
          if (cnt_q[2:0] == 3'h7 && extra_q != {`ATTEN_W{1'b0}})
            extra_d = extra_q - 5'h01;
          if (cnt_q == `RAMP_CYCLES - 8'h01) begin
            state_d = ST_IDLE;
            cnt_d = 8'h00;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end
        default: begin
          state_d = ST_IDLE;
          cnt_d = 8'h00;
        end
      endcase
    end
  end

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
      cnt_q <= 8'h00;
      extra_q <= {`ATTEN_W{1'b0}};
      MOD_RESET <= 1'b0;
      OVERLOAD <= 1'b0;
      RECOVERING <= 1'b0;
    end else if (CE) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      extra_q <= extra_d;
      MOD_RESET <= mod_reset_d;
      OVERLOAD <= overload_now;
      RECOVERING <= overload_now | (state_q != ST_IDLE);
    end
  end

  // Samples seen while the modulator is held are garbage and not counted
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      hist_q <= {`WINDOW_LEN{1'b0}};
    end else if (CE) begin
      if (overload_now)
        hist_q <= {`WINDOW_LEN{1'b0}};
      else if (take && state_q != ST_HOLD)
        hist_q <= hist_next;
    end
  end

  // One bit wider so a large setting plus boost saturates, never wraps
  assign atten_sum = {1'b0, ATTEN_PROG} + {1'b0, extra_q};

  always @(posedge SYS_CLK) begin
    if (SRST) begin
      ATTEN_OUT <= {`ATTEN_W{1'b0}};
    end else if (CE) begin
      if (atten_sum[`ATTEN_W])
        ATTEN_OUT <= `ATTEN_MAX;
      else
        ATTEN_OUT <= atten_sum[`ATTEN_W-1:0];
    end
  end

  // Clean only after a full quiet span with no detection inside it
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      quiet_q <= 8'h00;
      OUT_CLEAN <= 1'b0;
    end else if (CE) begin
      if (overload_now)
        quiet_q <= 8'h00;
      else if (quiet_q != `VALID_CYCLES)
        quiet_q <= quiet_q + 8'h01;
      OUT_CLEAN <= ~overload_now & (quiet_q == `VALID_CYCLES);
    end
  end

  always @* begin
    fill_d = fill_q;
    buf0_d = buf0_q;
    buf1_d = buf1_q;
    case ({take, pop})
      2'b10: begin
        if (fill_q == 2'h0)
          buf0_d = QSAMPLE;
        else
          buf1_d = QSAMPLE;
        fill_d = fill_q + 2'h1;
      end
      2'b01: begin
        buf0_d = buf1_q;
        fill_d = fill_q - 2'h1;
      end
      2'b11: begin
        if (fill_q == 2'h1) begin
          buf0_d = QSAMPLE;
        end else begin
          buf0_d = buf1_q;
          buf1_d = QSAMPLE;
        end
      end
      default: fill_d = fill_q;
    endcase
  end

  // Ready and valid are registered copies of the next fill level,
  // so a stalled receiver never costs a word
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      fill_q <= 2'h0;
      buf0_q <= {`SAMPLE_W{1'b0}};
      buf1_q <= {`SAMPLE_W{1'b0}};
      OUT_DATA <= {`SAMPLE_W{1'b0}};
      OUT_VALID <= 1'b0;
      QSAMPLE_READY <= 1'b0;
    end else if (CE) begin
      fill_q <= fill_d;
      buf0_q <= buf0_d;
      buf1_q <= buf1_d;
      OUT_DATA <= buf0_d;
      OUT_VALID <= (fill_d != 2'h0);
      QSAMPLE_READY <= (fill_d != 2'h2);
    end
  end

endmodule

// >>> tb/ovl_recovery_asserts.sv
`timescale 1ns/100ps
module ovl_recovery_asserts (
  input wire SYS_CLK, SRST, CE, QSAMPLE_VALID, QSAMPLE_READY, OUT_READY,
  input wire MOD_RESET, OVERLOAD, RECOVERING, OUT_VALID, OUT_CLEAN,
  input wire [4:0] QSAMPLE, ATTEN_PROG, ATTEN_OUT, OUT_DATA
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST || !CE);
  property p_det; OVERLOAD |-> MOD_RESET && RECOVERING; endproperty
  a_det: assert property (p_det) else $error("no hold");
  property p_hold; $fell(MOD_RESET) |-> $past(MOD_RESET, 16); endproperty
  a_hold: assert property (p_hold) else $error("hold short");
  property p_boost;
    OVERLOAD && ATTEN_PROG < 5'h1A |=> ATTEN_OUT == ATTEN_PROG + 5'h06;
  endproperty
  a_boost: assert property (p_boost) else $error("no boost");
  property p_ramp; $fell(RECOVERING) |-> ##[0:2] ATTEN_OUT == ATTEN_PROG;
  endproperty
  a_ramp: assert property (p_ramp) else $error("ramp end");
  property p_clean; OUT_CLEAN |-> !RECOVERING && !MOD_RESET; endproperty
  a_clean: assert property (p_clean) else $error("early clean");
  property p_clr; OVERLOAD |=> !OUT_CLEAN; endproperty
  a_clr: assert property (p_clr) else $error("clean kept");
  property p_pulse; OVERLOAD |=> !OVERLOAD; endproperty
  a_pulse: assert property (p_pulse) else $error("repeat");
  property p_stall; OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA);
  endproperty
  a_stall: assert property (p_stall) else $error("word lost");
  c_det: cover property (OVERLOAD);
  c_rec: cover property ($fell(RECOVERING));
  c_stall: cover property (OUT_VALID && !OUT_READY);
endmodule

// >>> tb/quant_model.sv
`timescale 1ns/100ps
module quant_model (
  input wire clk,
  input wire [2:0] mode,
  input wire rdy,
  output reg [4:0] q,
  output reg v
);
  reg [2:0] n = 3'h0;
  initial q = 5'h03;
  initial v = 1'b0;
  // A code stands until the block takes it
  always @(posedge clk) if (v && rdy) n <= n + 3'h1;
  always @(negedge clk) begin
    v <= 1'b1;
    case (mode)
      3'h1: q <= 5'h08;
      3'h2: q <= 5'h18;
      3'h3: q <= (n < 3'h5) ? 5'h08 : 5'h03;
      3'h4: q <= (n < 3'h6) ? 5'h18 : 5'h03;
      default: q <= 5'h03;
    endcase
  end
endmodule

// >>> tb/ovl_recovery_tb.sv
`timescale 1ns/100ps
module ovl_recovery_tb;
  reg SYS_CLK = 1'b0, SRST = 1'b1, OUT_READY = 1'b1, CE = 1'b1;
  reg [2:0] mode = 3'h0;
  reg [16:0] rows [0:5];
  wire [4:0] q, atten, odata;
  wire qv, qr, mr, ov, rec, oval, clean;
  integer errors = 0, n_tests = 0, i, nov, nmr;
  always #2 SYS_CLK = ~SYS_CLK;
  quant_model qm (.clk(SYS_CLK), .mode(mode), .rdy(qr & CE), .q(q), .v(qv));
  ovl_recovery DUT (.SYS_CLK(SYS_CLK), .SRST(SRST), .CE(CE), .QSAMPLE(q),
    .QSAMPLE_VALID(qv), .QSAMPLE_READY(qr), .ATTEN_PROG(5'h03),
    .MOD_RESET(mr), .ATTEN_OUT(atten), .OVERLOAD(ov), .RECOVERING(rec),
    .OUT_DATA(odata), .OUT_VALID(oval), .OUT_CLEAN(clean),
    .OUT_READY(OUT_READY));
  task check(input [7:0] seen, input [7:0] exp, input [63:0] what);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("Error %0s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task run(input integer n);
    repeat (n) begin
      @(negedge SYS_CLK);
      nov = nov + (ov === 1'b1);
      nmr = nmr + (mr === 1'b1);
    end
  endtask
  task complete_run;
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    // Row: mode, cycles of that mode, detections, held cycles
    rows[0] = {3'h0, 6'h28, 2'h0, 6'h00};
    rows[1] = {3'h1, 6'h0C, 2'h1, 6'h10};
    rows[2] = {3'h2, 6'h0C, 2'h1, 6'h10};
    rows[3] = {3'h3, 6'h28, 2'h0, 6'h00};
    rows[4] = {3'h4, 6'h10, 2'h1, 6'h10};
    rows[5] = {3'h1, 6'h23, 2'h2, 6'h20};
    repeat (10) @(negedge SYS_CLK);
    check({mr, ov, rec, oval, clean, atten[2:0]}, 8'h00, "reset");
    for (i = 0; i < 6; i = i + 1) begin
      SRST = 1'b1;
      @(negedge SYS_CLK);
      SRST = 1'b0;
      mode <= rows[i][16:14];
      nov = 0;
      nmr = 0;
      run(rows[i][13:8]);
      mode <= 3'h0;
      run(90);
      check(nov, rows[i][7:6], "detect");
      check(nmr, rows[i][5:0], "hold");
      check(atten, 8'h03, "atten");
      check(clean, 8'h01, "clean");
    end
    // Stalled receiver: buffer fills and refuses, head word kept
    OUT_READY = 1'b0;
    run(6);
    check({qr, oval, odata}, 8'h23, "full");
    OUT_READY = 1'b1;
    run(2);
    check(qr, 8'h01, "drain");
    // Clock enable low freezes the hold phase where it stands
    mode <= 3'h1;
    nmr = 0;
    run(8);
    CE = 1'b0;
    mode <= 3'h0;
    nmr = 0;
    run(40);
    check(nmr, 8'h28, "freeze");
    CE = 1'b1;
    run(80);
    check({mr, rec, atten}, 8'h03, "thaw");
    complete_run;
  end
endmodule
bind ovl_recovery ovl_recovery_asserts chk (.*);
